/* design/cfs_clock_fallback.sv */
// Secondary clock selection and sticky fallback control with APB registers
`timescale 1ns/1ps
module cfs_clock_fallback
  import cfs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Clock failure detectors, one per monitored source
  input  wire logic [7:0]  clk_fail,
  // Clock selection outputs
  output logic [2:0]       active_clock_sel,
  output logic [1:0]       pll_source_sel,
  output logic             ab_clock_enable,
  output logic             compat_clock_drive,
  output logic             mc1_mode,
  output logic             fallback_sm_enable,
  output logic             fallback_active,
  // Interrupt
  output logic             irq
);

  typedef enum {ST_NORMAL, ST_FALLBACK} cfs_state_t;

  typedef struct packed {
    logic [7:0]  secondary_clock_select;
    logic [3:0]  main_clock_reg;        // [3] bus_clock_input_sel, [2:0] main_clock_sel
    logic [7:0]  clk_err_enable;
    logic [7:0]  clock_error_reg;
    logic        sys_fb_flag;
    logic        irq_mask;
    logic [1:0]  sticky_fb_type;
    cfs_state_t  state;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [2:0]  active_clock_sel;
    logic [1:0]  pll_source_sel;
    logic        ab_clock_enable;
    logic        compat_clock_drive;
    logic        mc1_mode;
    logic        fallback_sm_enable;
    logic        fallback_active;
    logic        irq;
  } cfs_regs_t;

  // Reset release through two flops
  logic rst_meta;
  logic rst_sync_b;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // Valid address decode, used by the error answer and its check
  function automatic logic addr_known(input logic [7:0] a);
    case (a)
      ADDR_SECONDARY_CLOCK_SELECT, ADDR_MAIN_CLOCK, ADDR_CLOCK_ERROR_ENABLE,
      ADDR_CLOCK_ERROR, ADDR_SYSTEM_ERROR, ADDR_IRQ_MASK, ADDR_CONTROL,
      ADDR_STATUS: addr_known = 1'b1;
      default:     addr_known = 1'b0;
    endcase
  endfunction

  // Type that steers the switch: the live field under force, else the one latched at fallback time
  function automatic logic [1:0] eff_type(input logic f, input logic [1:0] live, input logic [1:0] latched);
    eff_type = f ? live : latched;
  endfunction

  cfs_regs_t r;
  cfs_regs_t next_r;

  logic       access_now;
  logic       wr_now;
  logic       rd_now;
  logic [1:0] fb_type;
  logic       force_fb;
  logic [2:0] sec_src;
  logic       fail_event;
  logic       sw_clear;
  logic       in_fallback;

  assign fb_type  = r.secondary_clock_select[POS_FB_TYPE +: 2];
  assign force_fb = r.secondary_clock_select[POS_FORCE_FB];
  assign sec_src  = r.secondary_clock_select[POS_SEC_SRC +: 3];
  // One wait state: the answer is registered, so pready rises in the access cycle's second edge
  assign access_now = psel && penable && !r.pready;
  // A write lands only at the edge where the master samples pready high, never earlier
  assign wr_now   = psel && penable && pwrite && r.pready;
  assign rd_now   = psel && penable && !pwrite && !r.pready;
  assign sw_clear = wr_now && (paddr == ADDR_CONTROL) && pwdata[POS_CLR_CLOCK_ERROR_REG];
  // Only enabled error bits count, and type 01 blocks the automatic path
  assign fail_event = |(clk_fail & r.clk_err_enable) && (fb_type != FB_DISABLED);
  assign in_fallback = (r.state == ST_FALLBACK) || force_fb;

  // Next-state logic for registers, fallback machine and outputs
  always_comb begin
    next_r = r;
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;
    // Error flags: the hardware set wins over a software clear in the same cycle
    next_r.clock_error_reg = (sw_clear ? 8'h00 : r.clock_error_reg) | clk_fail;
    // Answer: pready and the error flag rise together, one cycle into the access phase
    if (access_now) begin
      next_r.pready  = 1'b1;
      next_r.pslverr = !addr_known(paddr);
    end
    // Register writes, applied at the completing edge
    if (wr_now) begin
      case (paddr)
        ADDR_SECONDARY_CLOCK_SELECT: next_r.secondary_clock_select = pwdata[7:0];
        ADDR_MAIN_CLOCK:             next_r.main_clock_reg = pwdata[3:0];
        ADDR_CLOCK_ERROR_ENABLE:     next_r.clk_err_enable = pwdata[7:0];
        ADDR_IRQ_MASK:               next_r.irq_mask = pwdata[0];
        ADDR_SYSTEM_ERROR: begin
          // Write one to clear, a new fallback in the same cycle keeps it set
          if (pwdata[POS_FB_OCCURRED]) begin
            next_r.sys_fb_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Register reads
    if (rd_now) begin
      case (paddr)
        ADDR_SECONDARY_CLOCK_SELECT: next_r.prdata = {24'h00_0000, r.secondary_clock_select};
        ADDR_MAIN_CLOCK:             next_r.prdata = {28'h000_0000, r.main_clock_reg};
        ADDR_CLOCK_ERROR_ENABLE:     next_r.prdata = {24'h00_0000, r.clk_err_enable};
        ADDR_CLOCK_ERROR:            next_r.prdata = {24'h00_0000, r.clock_error_reg};
        ADDR_SYSTEM_ERROR:           next_r.prdata = {31'h0000_0000, r.sys_fb_flag};
        ADDR_IRQ_MASK:               next_r.prdata = {31'h0000_0000, r.irq_mask};
        ADDR_STATUS:                 next_r.prdata = {29'h0000_0000, r.sticky_fb_type,
                                                      r.state == ST_FALLBACK};
        default:                     next_r.prdata = 32'h0000_0000;
      endcase
    end
    // Sticky fallback machine; recovery of a clock never returns it to normal
    case (r.state)
      ST_NORMAL: begin
        if (fail_event) begin
          next_r.state          = ST_FALLBACK;
          next_r.sticky_fb_type = fb_type;
        end
      end
      ST_FALLBACK: begin
        if (sw_clear && !fail_event) begin
          next_r.state = ST_NORMAL;
        end
      end
      default: next_r.state = ST_NORMAL;
    endcase
    if ((r.state == ST_NORMAL) && fail_event) begin
      next_r.sys_fb_flag = 1'b1;
    end
    // Clock selection; the type latched at fallback time steers the switch, the live type under force
    next_r.pll_source_sel     = force_fb ? r.secondary_clock_select[POS_ALT_RES +: 2] : 2'h0;
    next_r.mc1_mode           = !r.main_clock_reg[POS_BUS_CLK_IN_SEL];
    next_r.fallback_sm_enable = (fb_type == FB_AB_TO_SEC);
    next_r.fallback_active    = in_fallback;
    next_r.ab_clock_enable    = 1'b1;
    next_r.compat_clock_drive = 1'b1;
    next_r.active_clock_sel   = r.main_clock_reg[2:0];
    if (in_fallback) begin
      case (eff_type(force_fb, fb_type, r.sticky_fb_type))
        FB_TO_OSC_DIV4: next_r.active_clock_sel = SRC_OSC_DIV4;
        FB_TO_SECOND:   next_r.active_clock_sel = sec_src;
        FB_AB_TO_SEC: begin
          next_r.active_clock_sel   = sec_src;
          next_r.ab_clock_enable    = 1'b0;
          next_r.compat_clock_drive = (sec_src != SRC_A_CLK) && (sec_src != SRC_B_CLK);
        end
        default:        next_r.active_clock_sel = sec_src;
      endcase
    end
    // Built from the next values so the line follows the flag and the mask with no extra lag
    next_r.irq = next_r.sys_fb_flag && next_r.irq_mask;
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      r                        <= '0;
      r.secondary_clock_select <= RST_SECONDARY_CLOCK_SELECT;
      r.main_clock_reg         <= RST_MAIN_CLOCK;
      r.clk_err_enable         <= RST_CLOCK_ERROR_ENABLE;
      r.state                  <= ST_NORMAL;
      r.ab_clock_enable        <= 1'b1;
      r.compat_clock_drive     <= 1'b1;
      r.mc1_mode               <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign pready             = r.pready;
  assign prdata             = r.prdata;
  assign pslverr            = r.pslverr;
  assign active_clock_sel   = r.active_clock_sel;
  assign pll_source_sel     = r.pll_source_sel;
  assign ab_clock_enable    = r.ab_clock_enable;
  assign compat_clock_drive = r.compat_clock_drive;
  assign mc1_mode           = r.mc1_mode;
  assign fallback_sm_enable = r.fallback_sm_enable;
  assign fallback_active    = r.fallback_active;
  assign irq                = r.irq;

  // Checks
  chk_fb_enter: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (r.state == ST_NORMAL && fail_event) |=> (r.state == ST_FALLBACK) ##1 fallback_active)
    else $error("fallback not entered after enabled failure");
  chk_fb_sticky: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (r.state == ST_FALLBACK && !sw_clear) |=> (r.state == ST_FALLBACK))
    else $error("fallback left without software clear");
  chk_fb_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (r.state == ST_FALLBACK && sw_clear && !fail_event) |=> (r.state == ST_NORMAL))
    else $error("software clear did not end fallback");
  chk_type_disabled: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (r.state == ST_NORMAL && fb_type == FB_DISABLED) |=> (r.state == ST_NORMAL))
    else $error("fallback occurred with type disabled");
  chk_sys_flag: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    $rose(r.state == ST_FALLBACK) |-> r.sys_fb_flag)
    else $error("system error flag missing after fallback");
  chk_osc_div4: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (r.state == ST_FALLBACK && !force_fb && r.sticky_fb_type == FB_TO_OSC_DIV4)
      |=> (active_clock_sel == SRC_OSC_DIV4))
    else $error("type 00 fallback not on oscillator divided by four");
  chk_secondary: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (r.state == ST_FALLBACK && !force_fb && r.sticky_fb_type == FB_TO_SECOND
      && $stable(sec_src)) |=> (active_clock_sel == $past(sec_src)))
    else $error("type 10 fallback not on secondary source");
  chk_ab_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (in_fallback && eff_type(force_fb, fb_type, r.sticky_fb_type) == FB_AB_TO_SEC) |=> !ab_clock_enable)
    else $error("A/B clocks left on in type 11 fallback");
  chk_force: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    force_fb |=> fallback_active)
    else $error("forced fallback not active");
  chk_mc1: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !r.main_clock_reg[POS_BUS_CLK_IN_SEL] |=> mc1_mode)
    else $error("MC-1 mode not shown");

  // Setting bus clock input select leaves MC-1 mode
  chk_mc1_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    r.main_clock_reg[POS_BUS_CLK_IN_SEL] |=> !mc1_mode)
    else $error("MC-1 mode kept with bus clock input select set");

  // Type 11 turns the fallback machine on
  chk_sm_enable: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (fb_type == FB_AB_TO_SEC) |=> fallback_sm_enable)
    else $error("fallback machine not enabled for type 11");

  // Other types leave the fallback machine off
  chk_sm_idle: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (fb_type != FB_AB_TO_SEC) |=> !fallback_sm_enable)
    else $error("fallback machine enabled for a type other than 11");

  // Under force the alternate resource field reaches the PLL source select
  chk_pll_force: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    force_fb |=> (pll_source_sel == $past(r.secondary_clock_select[POS_ALT_RES +: 2])))
    else $error("alternate resource not applied under force");

  // Without force the PLL source select stays at its idle code
  chk_pll_idle: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !force_fb |=> (pll_source_sel == 2'h0))
    else $error("alternate resource applied without force");

  // Forced type 10 selects the secondary source at once
  chk_force_second: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (force_fb && fb_type == FB_TO_SECOND) |=> (active_clock_sel == $past(sec_src)))
    else $error("forced type 10 not on secondary source");

  // Forced type 00 selects the oscillator divided by four
  chk_force_div4: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (force_fb && fb_type == FB_TO_OSC_DIV4) |=> (active_clock_sel == SRC_OSC_DIV4))
    else $error("forced type 00 not on oscillator divided by four");

  // Force overrides the diagnostic type 01, which then uses the secondary source
  chk_force_t01: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (force_fb && fb_type == FB_DISABLED) |=> (active_clock_sel == $past(sec_src)))
    else $error("forced type 01 not on secondary source");

  // Outside fallback the main selection drives the clock select
  chk_main_sel: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !in_fallback |=> (active_clock_sel == $past(r.main_clock_reg[2:0])))
    else $error("main clock selection not used outside fallback");

  // Outside fallback the A/B and compatibility clocks run normally
  chk_ab_normal: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    !in_fallback |=> (ab_clock_enable && compat_clock_drive))
    else $error("A/B or compatibility clocks off outside fallback");

  // Type 11 onto an A or B source stops driving the compatibility clocks
  chk_compat_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (in_fallback && eff_type(force_fb, fb_type, r.sticky_fb_type) == FB_AB_TO_SEC
      && (sec_src == SRC_A_CLK || sec_src == SRC_B_CLK)) |=> !compat_clock_drive)
    else $error("compatibility clocks still driven in type 11 fallback");

  // A new fallback keeps the system flag even against a same-cycle clear
  chk_flag_wins: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (r.state == ST_NORMAL && fail_event) |=> r.sys_fb_flag)
    else $error("system error flag lost on fallback");

  // The type in use at the failure is the one held for the whole fallback
  chk_type_latch: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (r.state == ST_NORMAL && fail_event) |=> (r.sticky_fb_type == $past(fb_type)))
    else $error("fallback type not latched at fallback");

  // A failing detector sets its error bit even against a same-cycle clear
  chk_err_wins: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (|clk_fail) |=> ((r.clock_error_reg & $past(clk_fail)) == $past(clk_fail)))
    else $error("clock error bit not set by a failing detector");

  // Interrupt line follows the unmasked system flag
  chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    irq == (r.sys_fb_flag && r.irq_mask))
    else $error("interrupt line does not follow the unmasked flag");

  // Each access is answered by a single pready pulse
  chk_pready_pulse: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    pready |=> !pready)
    else $error("pready held for more than one cycle");

  // Unmapped addresses are answered with an error
  chk_slverr: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (psel && penable && !r.pready && !addr_known(paddr)) |=> (pready && pslverr))
    else $error("unmapped access not answered with an error");
endmodule : cfs_clock_fallback

/* design/cfs_pkg.sv */
// Package of register map, field layout and encodings for the clock fallback block
package cfs_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_SECONDARY_CLOCK_SELECT = 8'h04;
  localparam logic [7:0] ADDR_MAIN_CLOCK             = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_ERROR_ENABLE     = 8'h0C;
  localparam logic [7:0] ADDR_CLOCK_ERROR            = 8'h10;
  localparam logic [7:0] ADDR_SYSTEM_ERROR           = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK               = 8'h18;
  localparam logic [7:0] ADDR_CONTROL                = 8'h1C;
  localparam logic [7:0] ADDR_STATUS                 = 8'h20;
  // Field positions of secondary_clock_select
  localparam int POS_ALT_RES  = 6;
  localparam int POS_FB_TYPE  = 4;
  localparam int POS_FORCE_FB = 3;
  localparam int POS_SEC_SRC  = 0;
  // Other field positions
  localparam int POS_BUS_CLK_IN_SEL = 3;  // In main clock register
  localparam int POS_CLR_CLOCK_ERROR_REG     = 0;  // In master control register
  localparam int POS_FB_OCCURRED    = 0;  // In system error register
  // Reset values
  localparam logic [7:0] RST_SECONDARY_CLOCK_SELECT = 8'h00;
  localparam logic [3:0] RST_MAIN_CLOCK             = 4'h0;
  localparam logic [7:0] RST_CLOCK_ERROR_ENABLE     = 8'hFF;
  // Fallback types
  localparam logic [1:0] FB_TO_OSC_DIV4 = 2'h0;
  localparam logic [1:0] FB_DISABLED    = 2'h1;
  localparam logic [1:0] FB_TO_SECOND   = 2'h2;
  localparam logic [1:0] FB_AB_TO_SEC   = 2'h3;
  // Clock source codes, shared by main and secondary selectors
  localparam logic [2:0] SRC_OSC_DIV4 = 3'h0;
  localparam logic [2:0] SRC_OSC      = 3'h1;
  localparam logic [2:0] SRC_A_CLK    = 3'h2;
  localparam logic [2:0] SRC_B_CLK    = 3'h3;
  localparam logic [2:0] SRC_NETREF   = 3'h4;
  localparam logic [2:0] SRC_LOCAL1   = 3'h5;
endpackage : cfs_pkg

/* dv/cfs_clock_fallback_tb.sv */
// Self-checking bench for the clock fallback block
`timescale 1ns/1ps
module cfs_clock_fallback_tb;
  import cfs_pkg::*;
  logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr, src_down, clk_fail;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  active_clock_sel;
  logic [1:0]  pll_source_sel;
  logic        ab_clock_enable, compat_clock_drive, mc1_mode, fallback_sm_enable, fallback_active;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;
  cfs_clock_fallback u_cfs_clock_fallback (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .clk_fail(clk_fail), .active_clock_sel(active_clock_sel), .pll_source_sel(pll_source_sel),
    .ab_clock_enable(ab_clock_enable), .compat_clock_drive(compat_clock_drive), .mc1_mode(mc1_mode),
    .fallback_sm_enable(fallback_sm_enable), .fallback_active(fallback_active), .irq(irq));
  cfs_clock_source_model u_cfs_clock_source_model (.clk_sys(clk_sys), .rst_b(rst_b), .src_down(src_down),
    .clk_fail(clk_fail));
  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Hang guard: the whole run needs a few hundred cycles, so this ceiling leaves ample room
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Outputs follow a cause within three edges, a source loss taking all three
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic trip();
    @(posedge clk_sys);
    src_down <= 8'h01;
    settle();
  endtask
  // Source comes back, then software clears the error flags
  task automatic heal();
    @(posedge clk_sys);
    src_down <= 8'h00;
    apb(1'b1, ADDR_CONTROL, 32'h0000_0001);
    settle();
  endtask
  task automatic t_reset();
    chk("mc1", 32'h1, 32'(mc1_mode));
    apb(1'b0, ADDR_SECONDARY_CLOCK_SELECT, 32'h0);
    chk("sel_rst", 32'(RST_SECONDARY_CLOCK_SELECT), rd);
    apb(1'b0, ADDR_CLOCK_ERROR_ENABLE, 32'h0);
    chk("en_rst", 32'(RST_CLOCK_ERROR_ENABLE), rd);
    apb(1'b1, ADDR_MAIN_CLOCK, 32'h0000_0008);
    settle();
    chk("mc1_off", 32'h0, 32'(mc1_mode));
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", 32'h0, rd);
  endtask
  task automatic t_disabled();
    apb(1'b1, ADDR_MAIN_CLOCK, 32'(SRC_A_CLK));
    apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, 32'h0000_0017);
    trip();
    chk("no_fb", 32'h0, 32'(fallback_active));
    chk("no_fb_sel", 32'(SRC_A_CLK), 32'(active_clock_sel));
    heal();
  endtask
  task automatic t_osc_div4();
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, 32'h0000_0007);
    trip();
    chk("div4_sel", 32'(SRC_OSC_DIV4), 32'(active_clock_sel));
    chk("div4_act", 32'h1, 32'(fallback_active));
    chk("irq_masked", 32'h0, 32'(irq));
    apb(1'b0, ADDR_SYSTEM_ERROR, 32'h0);
    chk("sys_flag", 32'h1, rd & 32'h1);
    apb(1'b0, ADDR_CLOCK_ERROR, 32'h0);
    chk("err_flags", 32'h0000_0001, rd);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_fb", 32'h0000_0001, rd);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    @(posedge clk_sys);
    src_down <= 8'h00;
    settle();
    chk("irq_on", 32'h1, 32'(irq));
    chk("sticky", 32'h1, 32'(fallback_active));
    chk("sticky_sel", 32'(SRC_OSC_DIV4), 32'(active_clock_sel));
    heal();
    chk("cleared", 32'h0, 32'(fallback_active));
    chk("main_back", 32'(SRC_A_CLK), 32'(active_clock_sel));
    apb(1'b0, ADDR_CLOCK_ERROR, 32'h0);
    chk("err_clr", 32'h0, rd);
    apb(1'b1, ADDR_SYSTEM_ERROR, 32'h0000_0001);
    settle();
    chk("irq_off", 32'h0, 32'(irq));
  endtask
  // Every secondary code is honoured on an automatic fallback
  task automatic t_secondary();
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, 32'h0000_0020 | 32'(c));
      trip();
      chk("sec_sel", 32'(c), 32'(active_clock_sel));
      heal();
    end
  endtask
  task automatic t_ab();
    apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, 32'h0000_0030 | 32'(SRC_B_CLK));
    trip();
    chk("ab_off", 32'h0, 32'(ab_clock_enable));
    chk("sm_on", 32'h1, 32'(fallback_sm_enable));
    chk("compat", 32'h0, 32'(compat_clock_drive));
    chk("ab_sel", 32'(SRC_B_CLK), 32'(active_clock_sel));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_ab", 32'h0000_0007, rd);
    heal();
    chk("ab_on", 32'h1, 32'(ab_clock_enable));
  endtask
  // Forced fallback with every alternate resource code
  task automatic t_force();
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, (32'(r) << POS_ALT_RES) | 32'h0000_002C);
      settle();
      chk("pll_src", 32'(r), 32'(pll_source_sel));
      chk("force_sel", 32'(SRC_NETREF), 32'(active_clock_sel));
      chk("force_act", 32'h1, 32'(fallback_active));
    end
    // Forced type 00, then forced type 01 on local reference one, then forced type 11 on A
    apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, 32'h0000_000C);
    settle();
    chk("force_div4", 32'(SRC_OSC_DIV4), 32'(active_clock_sel));
    apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, 32'h0000_001D);
    settle();
    chk("force_t01", 32'(SRC_LOCAL1), 32'(active_clock_sel));
    apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, 32'h0000_003A);
    settle();
    chk("force_ab", 32'h0, 32'(ab_clock_enable));
    chk("force_compat", 32'h0, 32'(compat_clock_drive));
    apb(1'b1, ADDR_SECONDARY_CLOCK_SELECT, 32'h0000_0024);
    settle();
    chk("unforced", 32'h0, 32'(fallback_active));
    chk("pll_idle", 32'h0, 32'(pll_source_sel));
    chk("sm_off", 32'h0, 32'(fallback_sm_enable));
    chk("ab_back", 32'h1, 32'(ab_clock_enable));
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_b    = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    src_down = 8'h00;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_disabled();
    t_osc_div4();
    t_secondary();
    t_ab();
    t_force();
    stop_test();
  end
endmodule // cfs_clock_fallback_tb

/* dv/cfs_clock_source_model.sv */
// Model of the redundant backplane clock sources, seen through their loss detectors
`timescale 1ns/1ps
module cfs_clock_source_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Sources that the bench takes down
  input  wire logic [7:0] src_down,
  // Detector levels toward the block
  output logic [7:0]      clk_fail
);
  typedef struct packed {
    logic [7:0] fail;
  } cfs_src_state_t;
  cfs_src_state_t state;
  cfs_src_state_t next_state;
  // A loss monitor reports one edge late, so the block never sees a same-edge change
  always_comb begin
    next_state      = state;
    next_state.fail = src_down;
  end
  // Detectors read clean after reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign clk_fail = state.fail;
endmodule // cfs_clock_source_model
